// >>> verilog/fpa_pkg.sv
// Shared constants, types and word selection for the flash accelerator
package fpa_pkg;

   // ==========================================================
   // Sizes
   localparam int AW     = 18;
   localparam int LW     = AW - 4;
   localparam int NBANK  = 2;
   localparam int LINE_W = 128;

   // ==========================================================
   // Values after reset and counts
   localparam logic [2:0]    TIM_RST   = 3'h7;
   localparam logic [2:0]    TIM_MIN   = 3'h1;
   localparam logic [2:0]    CNT_ONE   = 3'h1;
   localparam logic [2:0]    CNT_ZERO  = 3'h0;
   localparam logic [1:0]    WORD_LAST = 2'h3;
   localparam logic [LW-1:0] LINE_ONE  = LW'(1);
   localparam logic [LW-1:0] LINE_TWO  = LW'(2);

   // ==========================================================
   // Enumerations
   typedef enum logic [1:0] {
      MODE_OFF  = 2'h0,
      MODE_PART = 2'h1,
      MODE_FULL = 2'h2
   } fpa_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_WAIT = 2'h2
   } fpa_st_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic          valid;
      logic [AW-1:0] addr;
      logic          data;
      logic          seq;
      logic          half;
   } fpa_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } fpa_rsp_t;

   typedef struct packed {
      logic       load;
      logic [2:0] timing;
      logic [1:0] mode;
   } fpa_cfg_t;

   typedef struct packed {
      fpa_mode_t                   mode;
      logic [2:0]                  tim;
      fpa_st_t                     st;
      logic [NBANK-1:0]            busy;
      logic [NBANK-1:0]            pf;
      logic [NBANK-1:0]            dat;
      logic [NBANK-1:0][2:0]       cnt;
      logic [NBANK-1:0][LW-1:0]    line;
      logic [NBANK-1:0]            frd;
      logic [NBANK-1:0][LW-2:0]    fa;
      logic                        rsp_v;
      logic [31:0]                 rsp_data;
   } fpa_state_t;

   typedef struct packed {
      logic              valid;
      logic [LW-1:0]     tag;
      logic [LINE_W-1:0] data;
   } fpa_buf_t;

   // ==========================================================
   // Picks a 32-bit word or a 16-bit halfword out of a line
   function automatic logic [31:0] sel_word(
      input logic [LINE_W-1:0] line,
      input logic [2:0]        hsel,
      input logic              half);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (half) begin
         w = {16'h0000, line[{hsel, 4'h0} +: 16]};
      end else begin
         w = line[{hsel[2:1], 5'h00} +: 32];
      end
      return w;
   endfunction : sel_word

endpackage : fpa_pkg

// >>> verilog/fpa_line_buf.sv
// One 128-bit line holding latch with its comparison address
module fpa_line_buf (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire logic                      inv,
   input  wire logic                      load,
   input  wire logic [fpa_pkg::LW-1:0]     load_tag,
   input  wire logic [fpa_pkg::LINE_W-1:0] load_data,
   input  wire logic [fpa_pkg::LW-1:0]     look_tag,
   output logic                           hit,
   output logic [fpa_pkg::LINE_W-1:0]      data
);
   import fpa_pkg::*;

   fpa_buf_t s_q;
   fpa_buf_t s_d;

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      if (inv) begin
         s_d.valid = 1'b0;
      end else if (load) begin
         s_d.valid = 1'b1;
         s_d.tag   = load_tag;
         s_d.data  = load_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit  = s_q.valid && (s_q.tag == look_tag);
   assign data = s_q.data;

endmodule : fpa_line_buf

// >>> verilog/fpa_accel.sv
// Flash access accelerator with two banks, code and data line latches
// ==========================================================
// Notes on behaviour
// - Two independent banks, each with two buffers
// - Code miss loads the bank's trail buffer
// - Finished prefetch fills the bank's prefetch buffer
// - Lines give 32-bit words or 16-bit halves
// - Other bank prefetches the next sequential line
// - Last word used starts same-bank next line
// - Read duration set by programmable timing
// - Trail buffer hit needs no flash read
// - Prefetch buffer hit answers without stall
// - Full miss costs one access, reloads trail
// - Data reads use their own line buffer
// - Data never prefetched, read on demand
// - Address latch per bank, line incrementer
// - Prefetch reads ahead, fetch is requested
// - Modes off, sequential only, fully enabled
// - Programming start invalidates all latches
// - Fetch timing one to seven, resets seven
// - Comes up disabled, mode changeable anytime
module fpa_accel (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst_b,
   input  wire fpa_pkg::fpa_cfg_t                     cfg,
   input  wire fpa_pkg::fpa_req_t                     req,
   output fpa_pkg::fpa_rsp_t                          rsp,
   input  wire logic                                  prog_start,
   input  wire logic                                  flash_busy,
   output logic [fpa_pkg::NBANK-1:0]                  flash_rd,
   output logic [fpa_pkg::NBANK-1:0][fpa_pkg::LW-2:0] flash_addr,
   input  wire logic [fpa_pkg::NBANK-1:0][127:0]      flash_rdata
);
   import fpa_pkg::*;

   fpa_state_t                   s_q;
   fpa_state_t                   s_d;
   logic [NBANK-1:0]             pfb_hit;
   logic [NBANK-1:0]             btb_hit;
   logic [NBANK-1:0][127:0]      pfb_data;
   logic [NBANK-1:0][127:0]      btb_data;
   logic [NBANK-1:0]             pfb_ld;
   logic [NBANK-1:0]             btb_ld;
   logic                         dbuf_ld;
   logic                         dbuf_hit;
   logic [127:0]                 dbuf_data;
   logic                         dbank;
   logic [LW-1:0]                rline;
   logic                         rb;
   logic                         last;
   logic                         accel;
   logic [2:0]                   tim_eff;
   logic [NBANK-1:0]             done;
   logic [NBANK-1:0]             pf_go;
   logic [NBANK-1:0][LW-1:0]     pf_line;
   logic                         serve;
   logic [127:0]                 hit_line;

   assign rline   = req.addr[AW-1:4];
   assign rb      = rline[0];
   assign last    = (req.addr[3:2] == WORD_LAST) && (!req.half || req.addr[1]);
   assign accel   = (s_q.mode == MODE_PART) || (s_q.mode == MODE_FULL);
   assign tim_eff = (s_q.tim == CNT_ZERO) ? TIM_MIN : s_q.tim;
   assign dbank   = s_q.busy[1] && s_q.dat[1] && (s_q.cnt[1] == CNT_ZERO);

   // ==========================================================
   // Line latches, two per bank and one for data
   generate
      for (genvar b = 0; b < NBANK; b++) begin : g_bank
         fpa_line_buf u_pfb (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .inv       (prog_start),
            .load      (pfb_ld[b]),
            .load_tag  (s_q.line[b]),
            .load_data (flash_rdata[b]),
            .look_tag  (rline),
            .hit       (pfb_hit[b]),
            .data      (pfb_data[b])
         );
         fpa_line_buf u_btb (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .inv       (prog_start),
            .load      (btb_ld[b]),
            .load_tag  (s_q.line[b]),
            .load_data (flash_rdata[b]),
            .look_tag  (rline),
            .hit       (btb_hit[b]),
            .data      (btb_data[b])
         );
      end
   endgenerate

   fpa_line_buf u_dbuf (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .inv       (prog_start),
      .load      (dbuf_ld),
      .load_tag  (s_q.line[dbank]),
      .load_data (flash_rdata[dbank]),
      .look_tag  (rline),
      .hit       (dbuf_hit),
      .data      (dbuf_data)
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_d      = s_q;
      s_d.rsp_v = 1'b0;
      pfb_ld   = '0;
      btb_ld   = '0;
      dbuf_ld  = 1'b0;
      done     = '0;
      pf_go    = '0;
      pf_line  = '0;
      serve    = 1'b0;
      hit_line = req.data ? dbuf_data :
                 (pfb_hit[rb] ? pfb_data[rb] : btb_data[rb]);
      if (cfg.load) begin
         s_d.mode = fpa_mode_t'(cfg.mode);
         s_d.tim  = cfg.timing;
      end
      // Read completion per bank
      for (int b = 0; b < NBANK; b++) begin
         if (s_q.busy[b]) begin
            if (s_q.cnt[b] == CNT_ZERO) begin
               s_d.busy[b] = 1'b0;
               s_d.frd[b]  = 1'b0;
               done[b]     = 1'b1;
               if (s_q.dat[b]) begin
                  dbuf_ld = !prog_start;
               end else if (s_q.pf[b]) begin
                  pfb_ld[b] = !prog_start;
               end else begin
                  btb_ld[b] = !prog_start;
               end
            end else begin
               s_d.cnt[b] = s_q.cnt[b] - CNT_ONE;
            end
         end
      end
      case (s_q.st)
         ST_IDLE: begin
            if (req.valid && !s_q.rsp_v && !flash_busy) begin
               if (req.data) begin
                  serve = (s_q.mode == MODE_FULL) && dbuf_hit;
               end else begin
                  serve = (pfb_hit[rb] || btb_hit[rb]) &&
                          ((s_q.mode == MODE_FULL) ||
                           ((s_q.mode == MODE_PART) && req.seq));
               end
               if (serve) begin
                  s_d.rsp_v    = 1'b1;
                  s_d.rsp_data = sel_word(hit_line, req.addr[3:1],
                                          req.half);
                  pf_go[rb]    = accel && !req.data && last;
                  pf_line[rb]  = rline + LINE_TWO;
               end else begin
                  s_d.st = ST_WAIT;
                  if (!(accel && !req.data && s_q.busy[rb] &&
                        s_q.pf[rb] && s_q.line[rb] == rline)) begin
                     s_d.busy[rb] = 1'b1;
                     s_d.pf[rb]   = 1'b0;
                     s_d.dat[rb]  = req.data;
                     s_d.line[rb] = rline;
                     s_d.cnt[rb]  = tim_eff - CNT_ONE;
                     s_d.frd[rb]  = 1'b1;
                     s_d.fa[rb]   = rline[LW-1:1];
                  end
                  pf_go[!rb]   = accel && !req.data;
                  pf_line[!rb] = rline + LINE_ONE;
               end
            end
         end
         ST_WAIT: begin
            if (done[rb] && s_q.line[rb] == rline) begin
               s_d.st       = ST_IDLE;
               s_d.rsp_v    = 1'b1;
               s_d.rsp_data = sel_word(flash_rdata[rb], req.addr[3:1],
                                       req.half);
               pf_go[rb]    = accel && !req.data && last;
               pf_line[rb]  = rline + LINE_TWO;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
      // Speculative reads ahead of the core, code only
      for (int b = 0; b < NBANK; b++) begin
         if (pf_go[b] && !s_d.busy[b]) begin
            s_d.busy[b] = 1'b1;
            s_d.pf[b]   = 1'b1;
            s_d.dat[b]  = 1'b0;
            s_d.line[b] = pf_line[b];
            s_d.cnt[b]  = tim_eff - CNT_ONE;
            s_d.frd[b]  = 1'b1;
            s_d.fa[b]   = pf_line[b][LW-1:1];
         end
      end
      if (prog_start) begin
         s_d.busy  = '0;
         s_d.frd   = '0;
         s_d.st    = ST_IDLE;
         s_d.rsp_v = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q      <= '0;
         s_q.mode <= MODE_OFF;
         s_q.tim  <= TIM_RST;
         s_q.st   <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp        = '{valid: s_q.rsp_v, rdata: s_q.rsp_data};
   assign flash_rd   = s_q.frd;
   assign flash_addr = s_q.fa;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic idle_req;
   assign idle_req = (s_q.st == ST_IDLE) && req.valid && !s_q.rsp_v &&
                     !flash_busy && !prog_start && !cfg.load;

   a_tim_reset: assert property ($rose(rst_b) |-> s_q.tim == TIM_RST)
      else $error("fetch timing not seven after reset");
   a_mode_reset: assert property ($rose(rst_b) |->
                                  s_q.mode == MODE_OFF)
      else $error("accelerator not disabled after reset");
   a_prog_clear: assert property (prog_start |=> flash_rd == '0 &&
                                  !pfb_hit[0] && !btb_hit[0] && !dbuf_hit)
      else $error("latches survive programming start");
   a_hit_fast: assert property (idle_req && s_q.mode == MODE_FULL &&
                                !req.data && (pfb_hit[rb] || btb_hit[rb])
                                |=> rsp.valid && s_q.st == ST_IDLE)
      else $error("buffered branch target stalled");
   a_mode0_fetch: assert property (idle_req && s_q.mode == MODE_OFF
                                   |=> s_q.st == ST_WAIT && flash_rd[rb])
      else $error("disabled mode served from latch");
   a_read_len: assert property ($rose(s_q.busy[0])
                                |-> s_q.cnt[0] == $past(tim_eff) - CNT_ONE)
      else $error("read length differs from timing");
   a_wait_bound: assert property (s_q.st == ST_WAIT |-> ##[1:16]
                                  (rsp.valid || prog_start || flash_busy))
      else $error("core stalled too long");
   a_data_line: assert property (s_q.busy[0] && s_q.dat[0] &&
                                 s_q.cnt[0] == CNT_ZERO |-> !btb_ld[0])
      else $error("data read loaded code latch");
   a_data_no_pf: assert property (s_q.pf[0] && s_q.busy[0]
                                  |-> !s_q.dat[0])
      else $error("speculative data read");
   a_seq_pf: assert property (idle_req && s_q.mode == MODE_PART &&
                              !req.data && !req.seq && !s_q.busy[!rb]
                              |=> s_q.busy[!rb] && s_q.pf[!rb])
      else $error("next line not prefetched");

   c_hit_full: cover property (idle_req && s_q.mode == MODE_FULL ##1
                               rsp.valid);
   c_miss_wait: cover property (s_q.st == ST_WAIT ##[1:8] rsp.valid);
   c_data_hit: cover property (dbuf_hit && req.data && rsp.valid);
   c_prefetch: cover property (pfb_ld[1]);

endmodule : fpa_accel

// >>> tb/fpa_flash_model.sv
// Behavioural model of the two flash banks behind the accelerator
module fpa_flash_model (
   input  wire logic                                       clk_sys,
   input  wire logic [fpa_pkg::NBANK-1:0]                  flash_rd,
   input  wire logic [fpa_pkg::NBANK-1:0][fpa_pkg::LW-2:0] flash_addr,
   output logic      [fpa_pkg::NBANK-1:0][127:0]           flash_rdata,
   output logic      [fpa_pkg::NBANK-1:0][15:0]            n_start
);
   timeunit 1ns;
   timeprecision 1ps;
   import fpa_pkg::*;

   logic [NBANK-1:0]         rd_q;
   logic [NBANK-1:0][LW-2:0] addr_q;

   initial begin
      rd_q = '0;
      addr_q = '0;
      n_start = '0;
   end

   // ==========================================================
   // Read data: unique per word, inverted while no read is driven
   always_comb begin
      for (int b = 0; b < NBANK; b++) begin
         for (int w = 0; w < 4; w++) begin
            flash_rdata[b][w*32 +: 32] =
               {8'hC5, 4'h0, flash_addr[b], 1'(b), 4'h0, 2'(w)};
            if (!flash_rd[b]) begin
               flash_rdata[b][w*32 +: 32] = ~flash_rdata[b][w*32 +: 32];
            end
         end
      end
   end

   // ==========================================================
   // Counts reads started on each bank
   always @(posedge clk_sys) begin
      rd_q <= flash_rd;
      addr_q <= flash_addr;
      for (int b = 0; b < NBANK; b++) begin
         if (flash_rd[b] && !(rd_q[b] && addr_q[b] == flash_addr[b])) begin
            n_start[b] <= n_start[b] + 16'h0001;
         end
      end
   end

endmodule : fpa_flash_model

// >>> tb/tb.sv
// Self-checking testbench of the flash accelerator
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fpa_pkg::*;

   logic                            clk_sys;
   logic                            rst_b;
   fpa_cfg_t                        cfg;
   fpa_req_t                        req;
   fpa_rsp_t                        rsp;
   logic                            prog_start;
   logic                            flash_busy;
   logic [NBANK-1:0]                flash_rd;
   logic [NBANK-1:0][LW-2:0]        flash_addr;
   logic [NBANK-1:0][127:0]         flash_rdata;
   logic [NBANK-1:0][15:0]          n_start;
   int                              fails;
   int                              n_tests;

   fpa_accel uut (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .cfg         (cfg),
      .req         (req),
      .rsp         (rsp),
      .prog_start  (prog_start),
      .flash_busy  (flash_busy),
      .flash_rd    (flash_rd),
      .flash_addr  (flash_addr),
      .flash_rdata (flash_rdata)
   );

   fpa_flash_model flash (
      .clk_sys     (clk_sys),
      .flash_rd    (flash_rd),
      .flash_addr  (flash_addr),
      .flash_rdata (flash_rdata),
      .n_start     (n_start)
   );

   always #4 clk_sys = ~clk_sys;

   // ==========================================================
   // Compare and bus tasks
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_i(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         fails++;
         $display("BAD %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_i

   function automatic logic [31:0] exp_w(input logic [AW-1:0] a,
                                         input logic h);
      logic [31:0] w;
      w = {8'hC5, 4'h0, a[17:4], 4'h0, a[3:2]};
      if (h) begin
         w = a[1] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
      end
      return w;
   endfunction : exp_w

   task automatic set_cfg(input logic [1:0] m, input logic [2:0] t);
      @(posedge clk_sys);
      #1;
      cfg = '{load: 1'b1, timing: t, mode: m};
      @(posedge clk_sys);
      #1;
      cfg.load = 1'b0;
   endtask : set_cfg

   task automatic fetch(input logic [AW-1:0] a, input logic d,
                        input logic s, input logic h, input int lat);
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      req = '{valid: 1'b1, addr: a, data: d, seq: s, half: h};
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (rsp.valid !== 1'b1 && n < 20);
      req.valid = 1'b0;
      chk_i(n, lat);
      chk_w(rsp.rdata, exp_w(a, h));
   endtask : fetch

   // ==========================================================
   // Scenarios
   task automatic s_reset();
      int n1;
      chk_w({30'h0, flash_rd}, 32'h0000_0000);
      n1 = int'(n_start[1]);
      fetch(18'h00100, 1'b0, 1'b0, 1'b0, 8);
      fetch(18'h00100, 1'b0, 1'b1, 1'b0, 8);
      chk_i(int'(n_start[1]) - n1, 0);
   endtask : s_reset

   task automatic s_timing();
      int n0;
      for (int t = 1; t < 8; t++) begin
         set_cfg(2'h2, 3'(t));
         n0 = int'(n_start[0]);
         fetch(AW'(18'h00400 + t * 64), 1'b0, 1'b0, 1'b0, t + 1);
         chk_i(int'(n_start[0]) - n0, 1);
      end
   endtask : s_timing

   task automatic s_mode1();
      set_cfg(2'h1, 3'h2);
      fetch(18'h00800, 1'b0, 1'b0, 1'b0, 3);
      fetch(18'h00804, 1'b0, 1'b1, 1'b0, 1);
      fetch(18'h00808, 1'b0, 1'b0, 1'b0, 3);
      fetch(18'h00900, 1'b1, 1'b0, 1'b0, 3);
      fetch(18'h00904, 1'b1, 1'b1, 1'b0, 3);
   endtask : s_mode1

   task automatic s_half();
      set_cfg(2'h2, 3'h2);
      for (int i = 0; i < 8; i++) begin
         fetch(AW'(18'h00A00 + 2 * i), 1'b0, i != 0, 1'b1,
               (i == 0) ? 3 : 1);
      end
   endtask : s_half

   task automatic s_pref();
      int n1;
      int found;
      found = 0;
      set_cfg(2'h2, 3'h3);
      fetch(18'h00C0C, 1'b0, 1'b0, 1'b0, 4);
      for (int i = 0; i < 6 && found == 0; i++) begin
         @(posedge clk_sys);
         #1;
         found = int'(flash_rd[0] && flash_addr[0] == 13'h0061);
      end
      chk_i(found, 1);
      repeat (4) @(posedge clk_sys);
      n1 = int'(n_start[1]);
      fetch(18'h00C10, 1'b0, 1'b1, 1'b0, 1);
      fetch(18'h00C14, 1'b0, 1'b0, 1'b0, 1);
      chk_i(int'(n_start[1]) - n1, 0);
   endtask : s_pref

   task automatic s_data();
      int n1;
      set_cfg(2'h2, 3'h2);
      n1 = int'(n_start[1]);
      fetch(18'h00E00, 1'b1, 1'b0, 1'b0, 3);
      chk_i(int'(n_start[1]) - n1, 0);
      fetch(18'h00E08, 1'b1, 1'b0, 1'b0, 1);
      fetch(18'h00E04, 1'b0, 1'b0, 1'b0, 3);
   endtask : s_data

   task automatic s_prog();
      set_cfg(2'h2, 3'h2);
      fetch(18'h01000, 1'b0, 1'b0, 1'b0, 3);
      fetch(18'h01004, 1'b0, 1'b1, 1'b0, 1);
      @(posedge clk_sys);
      #1;
      prog_start = 1'b1;
      flash_busy = 1'b1;
      @(posedge clk_sys);
      #1;
      prog_start = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      flash_busy = 1'b0;
      fetch(18'h01004, 1'b0, 1'b1, 1'b0, 3);
   endtask : s_prog

   task automatic s_busy();
      set_cfg(2'h3, 3'h0);
      fetch(18'h01004, 1'b0, 1'b1, 1'b0, 2);
      @(posedge clk_sys);
      #1;
      flash_busy = 1'b1;
      req = '{valid: 1'b1, addr: 18'h01008, data: 1'b0, seq: 1'b0,
              half: 1'b0};
      repeat (3) begin
         @(posedge clk_sys);
         #1;
         chk_w({29'h0, rsp.valid, flash_rd}, 32'h0000_0000);
      end
      flash_busy = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk_w({31'h0, rsp.valid}, 32'h0000_0001);
      chk_w(rsp.rdata, exp_w(18'h01008, 1'b0));
      req.valid = 1'b0;
   endtask : s_busy

   // ==========================================================
   // Verdict, watchdog and main sequence
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      #20us;
      fails++;
      test_done();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      cfg = '0;
      req = '0;
      prog_start = 1'b0;
      flash_busy = 1'b0;
      fails = 0;
      n_tests = 0;
      repeat (3) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      s_reset();
      s_timing();
      s_mode1();
      s_half();
      s_pref();
      s_data();
      s_prog();
      s_busy();
      test_done();
   end

endmodule : tb
